// >>> hdl/signal_capture_trap_monitor.sv
// Notes on behaviour
// - Follow mode: indicators track input lines directly.
// - Bank A: 18 latches, no compare.
// - Bank B: 18 latches, ternary compare on latches.
// - Bank C: ten latches, compare on live lines.
// - No capture starts while qualifier mismatches.
// - Trigger is qualifier AND probe.
// - Probe off, high-active or low-active.
// - Gated: set window follows trigger, error drops.
// - Gated: high line latches on, stays on.
// - Sampled: 150 ns set pulse on trigger.
// - Follow mode ignores trigger and hold controls.
// - Hold: match sets trap, blocks auto reset.
// - Match off: result still drives match pulse and gated auto-off.
// - Match trigger joins trigger, sampled only.
// - Trigger search transparent, then capture and trap.
// - Match sense selectable: equal or differ.
// - After setting, match gives 150 ns pulse.
// - Strap enables halt request on trap.
// - Error before sample traps empty banks.
// - Error hold sets trap, forces set low.
// - Lock set on trigger, cleared by reset.
// - Gated auto-off resets unless match; else end-op.
// - Trap cleared only by manual reset.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`include "capture_consts.svh"
module signal_capture_trap_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire capture_pkg::monitored_type lines,
  output logic match_pulse_output,
  output logic processor_halt_request,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import capture_pkg::*;

  localparam int IW = $bits(monitored_type);
  localparam logic [5:0] PULSE_CYC = 6'(`PULSE_CYC);

  logic [IW-1:0] s1_ff, s2_ff, s3_ff, live_ff;
  monitored_type live;
  logic [31:0] ctrl_ff;
  logic [`BANK_B_W-1:0] b_care_ff, b_val_ff, bank_b_ff;
  logic [`BANK_C_W-1:0] c_care_ff, c_val_ff, bank_c_ff;
  logic [`BANK_A_W-1:0] bank_a_ff;
  mode_type mode;
  probe_type probe_sel;
  match_type match_sel;
  auto_type auto_sel;
  state_type state_ff, nxt_state;
  logic [5:0] cnt_ff, pulse_cnt_ff, len_ff;
  logic trap_ff, lock_ff, trig_q_ff, err_q_ff, eop_q_ff, post_ff, manual_ff;
  logic qual_match, b_equal, capture_match, probe_ok, capture_trigger;
  logic start, searching, trig_mode, set_active, set_fall, end_cond;
  logic eop_sel, auto_rst, trap_set, err_hit;

  // Three stages; a change is accepted once stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= lines;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  generate
    for (genvar gi = 0; gi < IW; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (reset) begin
          live_ff[gi] <= 1'b0;
        end else if (s2_ff[gi] == s3_ff[gi]) begin
          live_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate

  assign live = live_ff;
  assign mode = mode_type'(ctrl_ff[`CTRL_MODE_LSB +: 2]);
  assign probe_sel = probe_type'(ctrl_ff[`CTRL_PROBE_LSB +: 2]);
  assign match_sel = match_type'(ctrl_ff[`CTRL_MATCH_LSB +: 2]);
  assign auto_sel = auto_type'(ctrl_ff[`CTRL_AUTO_LSB +: 2]);

  // Qualifier looks at live lines, bank B compare at the latches
  assign qual_match = &(~c_care_ff | ~(live.c ^ c_val_ff));
  assign b_equal = &(~b_care_ff | ~(bank_b_ff ^ b_val_ff));
  assign capture_match = b_equal ^ ctrl_ff[`CTRL_SENSE_BIT];

  always_comb begin
    case (probe_sel)
      PROBE_OFF: probe_ok = 1'b1;
      PROBE_HIGH: probe_ok = live.probe;
      PROBE_LOW: probe_ok = ~live.probe;
      default: probe_ok = 1'b0;
    endcase
  end

  assign trig_mode = (match_sel == MATCH_TRIGGER) && (mode == MODE_SAMPLED);
  assign capture_trigger = qual_match & probe_ok & (~trig_mode | capture_match);
  assign searching = trig_mode & ~lock_ff & ~trap_ff;
  // Follow mode never starts a capture, so hold and trigger settings are moot
  assign start = capture_trigger & ~trig_q_ff & ~lock_ff & ~trap_ff & ~err_hit
                 & (mode == MODE_SAMPLED || mode == MODE_GATED);
  assign set_active = (state_ff == ST_SET) & (~trap_ff | trig_mode);
  assign err_hit = ctrl_ff[`CTRL_ERRHOLD_BIT] & live.device_error & ~err_q_ff;
  assign end_cond = err_hit | (trap_ff & ~trig_mode)
                    | ((mode == MODE_GATED) ? ~capture_trigger
                                            : (cnt_ff == 6'h01));
  assign set_fall = (state_ff == ST_SET) & end_cond;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start) nxt_state = ST_SET;
      ST_SET: if (end_cond || manual_ff) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_ff <= 6'h00;
    end else if (start) begin
      cnt_ff <= PULSE_CYC;
    end else if (cnt_ff != 6'h00) begin
      cnt_ff <= cnt_ff - 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      trig_q_ff <= 1'b0;
      err_q_ff <= 1'b0;
      eop_q_ff <= 1'b0;
      post_ff <= 1'b0;
    end else begin
      trig_q_ff <= capture_trigger;
      err_q_ff <= live.device_error;
      eop_q_ff <= eop_sel;
      post_ff <= set_fall & (mode != MODE_FOLLOW);
    end
  end

  assign eop_sel = (auto_sel == AUTO_EOP_ONE) ? live.end_of_operation_one
                 : (auto_sel == AUTO_EOP_TWO) ? live.end_of_operation_two : 1'b0;
  // A trap freezes the banks against every automatic reset
  assign auto_rst = ~trap_ff & (mode != MODE_FOLLOW) & ((eop_sel & ~eop_q_ff)
                  | (post_ff & mode == MODE_GATED & auto_sel == AUTO_OFF
                     & ~capture_match));

  assign trap_set = (mode != MODE_FOLLOW) & (
                      (post_ff & match_sel == MATCH_HOLD & capture_match)
                    | (start & trig_mode)
                    | err_hit);

  // Setting wins over the manual clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      trap_ff <= 1'b0;
    end else if (trap_set) begin
      trap_ff <= 1'b1;
    end else if (manual_ff) begin
      trap_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lock_ff <= 1'b0;
    end else if (start) begin
      lock_ff <= 1'b1;
    end else if (manual_ff || auto_rst) begin
      lock_ff <= 1'b0;
    end
  end

  // Banks: an error before the sample leaves them empty and trapped
  always_ff @(posedge mclk) begin
    if (reset) begin
      bank_a_ff <= '0;
      bank_b_ff <= '0;
      bank_c_ff <= '0;
    end else if (mode == MODE_FOLLOW || searching) begin
      bank_a_ff <= live.a;
      bank_b_ff <= live.b;
      bank_c_ff <= live.c;
    end else if (manual_ff || auto_rst) begin
      bank_a_ff <= '0;
      bank_b_ff <= '0;
      bank_c_ff <= '0;
    end else if (set_active) begin
      bank_a_ff <= bank_a_ff | live.a;
      bank_b_ff <= bank_b_ff | live.b;
      bank_c_ff <= bank_c_ff | live.c;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_cnt_ff <= 6'h00;
    end else if (post_ff && capture_match) begin
      pulse_cnt_ff <= PULSE_CYC;
    end else if (pulse_cnt_ff != 6'h00) begin
      pulse_cnt_ff <= pulse_cnt_ff - 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      match_pulse_output <= 1'b0;
      processor_halt_request <= 1'b0;
    end else begin
      match_pulse_output <= (post_ff && capture_match) || (pulse_cnt_ff > 6'h01);
      processor_halt_request <= trap_ff & live.halt_strap;
    end
  end

  // Register bus: one write and one read in flight
  logic aw_got_ff, w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, wmask, rd_val;
  logic [3:0] wstrb_ff;
  logic rd_ok, wr_ok;

  assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_ok = (awaddr_ff <= `REG_C_VALUE) && (awaddr_ff[1:0] == 2'h0)
                 || (awaddr_ff == `REG_MANUAL);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [31:0] m);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (aw_got_ff && w_got_ff) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire do_wr = aw_got_ff & w_got_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff <= `CTRL_RESET_VAL;
      b_care_ff <= '0;
      b_val_ff <= '0;
      c_care_ff <= '0;
      c_val_ff <= '0;
    end else if (do_wr) begin
      case (awaddr_ff)
        `REG_CTRL: ctrl_ff <= merge(ctrl_ff, wdata_ff, wmask & 32'h0000_03FF);
        `REG_B_CARE: b_care_ff <= `BANK_B_W'(merge(32'(b_care_ff), wdata_ff, wmask));
        `REG_B_VALUE: b_val_ff <= `BANK_B_W'(merge(32'(b_val_ff), wdata_ff, wmask));
        `REG_C_CARE: c_care_ff <= `BANK_C_W'(merge(32'(c_care_ff), wdata_ff, wmask));
        `REG_C_VALUE: c_val_ff <= `BANK_C_W'(merge(32'(c_val_ff), wdata_ff, wmask));
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      manual_ff <= 1'b0;
    end else begin
      manual_ff <= do_wr && awaddr_ff == `REG_MANUAL && wstrb_ff[0] && wdata_ff[0];
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL: rd_val = ctrl_ff;
      `REG_B_CARE: rd_val = 32'(b_care_ff);
      `REG_B_VALUE: rd_val = 32'(b_val_ff);
      `REG_C_CARE: rd_val = 32'(c_care_ff);
      `REG_C_VALUE: rd_val = 32'(c_val_ff);
      `REG_STATUS: rd_val = {27'h0, qual_match, capture_match,
                             (mode == MODE_FOLLOW) | set_active, lock_ff, trap_ff};
      `REG_BANK_A: rd_val = 32'(bank_a_ff);
      `REG_BANK_B: rd_val = 32'(bank_b_ff);
      `REG_BANK_C: rd_val = 32'(bank_c_ff);
      `REG_MANUAL: rd_val = 32'h0000_0000;
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Helper: cycles spent in the set window so far
  always_ff @(posedge mclk) begin
    if (reset || start) begin
      len_ff <= 6'h00;
    end else if (state_ff == ST_SET && len_ff != 6'h3F) begin
      len_ff <= len_ff + 6'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_follow_tracks: assert property (
    (mode == MODE_FOLLOW && $past(mode) == MODE_FOLLOW) |-> bank_a_ff == $past(live.a))
    else $error("follow mode bank A not tracking lines");
  chk_qualified_start: assert property (
    (state_ff == ST_IDLE && !qual_match) |=> !set_active) else $error("set without qualifier");
  chk_sample_width: assert property (
    (set_fall && mode == MODE_SAMPLED && !err_hit && (trig_mode || !trap_ff))
    |-> len_ff == PULSE_CYC - 6'h01) else $error("sampled set window has wrong length");
  chk_trap_no_auto: assert property (
    (trap_ff && !manual_ff && mode != MODE_FOLLOW && state_ff == ST_IDLE)
    |=> $stable(bank_b_ff)) else $error("trapped bank changed");
  chk_gated_sticky: assert property (
    (mode == MODE_GATED && set_active && bank_a_ff[0] && !manual_ff && !auto_rst)
    |=> bank_a_ff[0]) else $error("gated latch lost its bit");
  chk_match_pulse: assert property (
    (post_ff && capture_match) |=> match_pulse_output [*8])
    else $error("match pulse too short");
  chk_trap_manual: assert property (
    (trap_ff && !manual_ff) |=> trap_ff) else $error("trap cleared without manual reset");
  chk_trap_drops_set: assert property (
    (err_hit && mode != MODE_FOLLOW) |=> trap_ff && !set_active) else $error("no error trap");
  chk_lock_blocks: assert property (
    (lock_ff && state_ff == ST_IDLE && !manual_ff && !auto_rst)
    |=> lock_ff && state_ff == ST_IDLE) else $error("trigger accepted while locked");
  chk_halt_follows: assert property (
    (trap_ff && live.halt_strap) |=> processor_halt_request)
    else $error("halt request missing on trap");
endmodule : signal_capture_trap_monitor

// >>> shared/capture_consts.svh
`ifndef CAPTURE_CONSTS_SVH
`define CAPTURE_CONSTS_SVH
`define BANK_A_W 18
`define BANK_B_W 18
`define BANK_C_W 10
`define REG_CTRL 8'h00
`define REG_B_CARE 8'h04
`define REG_B_VALUE 8'h08
`define REG_C_CARE 8'h0C
`define REG_C_VALUE 8'h10
`define REG_STATUS 8'h14
`define REG_BANK_A 8'h18
`define REG_BANK_B 8'h1C
`define REG_BANK_C 8'h20
`define REG_MANUAL 8'h24
`define CTRL_MODE_LSB 0
`define CTRL_PROBE_LSB 2
`define CTRL_MATCH_LSB 4
`define CTRL_SENSE_BIT 6
`define CTRL_ERRHOLD_BIT 7
`define CTRL_AUTO_LSB 8
`define CTRL_RESET_VAL 32'h0000_0000
`define CLK_MHZ 250
`define PULSE_NS 150
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`endif

// >>> shared/capture_pkg.sv
`include "capture_consts.svh"
package capture_pkg;
  typedef enum logic [1:0] {
    MODE_FOLLOW = 2'h0, MODE_SAMPLED = 2'h1, MODE_GATED = 2'h2, MODE_SPARE = 2'h3
  } mode_type;
  typedef enum logic [1:0] {
    PROBE_OFF = 2'h0, PROBE_HIGH = 2'h1, PROBE_LOW = 2'h2, PROBE_SPARE = 2'h3
  } probe_type;
  typedef enum logic [1:0] {
    MATCH_OFF = 2'h0, MATCH_HOLD = 2'h1, MATCH_TRIGGER = 2'h2, MATCH_SPARE = 2'h3
  } match_type;
  typedef enum logic [1:0] {
    AUTO_OFF = 2'h0, AUTO_EOP_ONE = 2'h1, AUTO_EOP_TWO = 2'h2, AUTO_SPARE = 2'h3
  } auto_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_SET = 2'b10
  } state_type;
  typedef struct packed {
    logic [`BANK_A_W-1:0] a;
    logic [`BANK_B_W-1:0] b;
    logic [`BANK_C_W-1:0] c;
    logic probe;
    logic device_error;
    logic end_of_operation_one;
    logic end_of_operation_two;
    logic halt_strap;
  } monitored_type;
endpackage : capture_pkg

// >>> sim/adapter_model.sv
module adapter_model (
  input wire logic mclk,
  input wire capture_pkg::monitored_type want,
  output capture_pkg::monitored_type lines
);
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  // The adapter's own logic moves its lines only at its clock edge
  always @(posedge mclk) begin
    lines <= want;
  end
endmodule : adapter_model

// >>> sim/tb_signal_capture_trap_monitor.sv
`include "capture_consts.svh"
module tb_signal_capture_trap_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  logic mclk;
  logic reset;
  monitored_type want;
  monitored_type lines;
  logic match_pulse_output;
  logic processor_halt_request;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  int error_cnt;
  int checks_done;
  logic [31:0] rd;
  logic [1:0] rsp;

  adapter_model adapter_model_inst (.mclk(mclk), .want(want), .lines(lines));
  signal_capture_trap_monitor signal_capture_trap_monitor_inst (
    .mclk(mclk), .reset(reset), .lines(lines), .match_pulse_output(match_pulse_output),
    .processor_halt_request(processor_halt_request), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  task automatic give_up(input int n);
    if (n >= 64) begin
      error_cnt++;
      $display("Error bus wait expected answer seen none");
      end_of_test();
    end
  endtask : give_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    give_up(n);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    give_up(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  // Lines cross three flops and a filter before the core sees them
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask : settle

  task automatic manual_clear();
    wr(`REG_MANUAL, 32'h0000_0001, rsp);
    settle(4);
  endtask : manual_clear

  task automatic check_pulse(input int exp_len);
    int n;
    int len;
    len = 0;
    for (n = 0; n < 120 && match_pulse_output !== 1'b1; n++) @(posedge mclk);
    while (match_pulse_output === 1'b1 && len < 100) begin
      @(posedge mclk);
      len++;
    end
    cmp_word("pulse width", exp_len, len);
  endtask : check_pulse

  task automatic t_reset_values();
    rdr(`REG_CTRL, rd, rsp);
    cmp_word("ctrl reset", `CTRL_RESET_VAL, rd);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("status reset", 32'h0000_001c, rd);
    rdr(8'h28, rd, rsp);
    cmp_word("unmapped read resp", 32'h0000_0002, {30'h0, rsp});
    wr(8'h28, 32'h0000_ffff, rsp);
    cmp_word("unmapped write resp", 32'h0000_0002, {30'h0, rsp});
  endtask : t_reset_values

  task automatic t_follow();
    want.a <= 18'h2_a5a5;
    want.probe <= 1'b1;
    settle(8);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("follow bank a", 32'h0002_a5a5, rd);
    want.a <= 18'h1_5a5a;
    settle(8);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("follow bank a drop", 32'h0001_5a5a, rd);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("follow no lock", 32'h0000_0000, rd & 32'h0000_0003);
    want <= '0;
    settle(8);
  endtask : t_follow

  task automatic t_gated();
    wr(`REG_C_CARE, 32'h0000_0001, rsp);
    wr(`REG_C_VALUE, 32'h0000_0001, rsp);
    wr(`REG_CTRL, 32'h0000_000a, rsp);
    manual_clear();
    want.a <= 18'h0_0003;
    settle(8);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("qualifier blocks set", 32'h0000_0000, rd);
    want.c[0] <= 1'b1;
    settle(8);
    want.a <= 18'h0_0010;
    settle(8);
    want.a <= 18'h0_0000;
    settle(8);
    want.probe <= 1'b1;
    check_pulse(`PULSE_CYC);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("gated bank a", 32'h0000_0013, rd);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("gated lock", 32'h0000_0002, rd & 32'h0000_0003);
    want.a <= 18'h0_0100;
    want.probe <= 1'b0;
    settle(20);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("lock blocks retrigger", 32'h0000_0013, rd);
  endtask : t_gated

  task automatic t_sampled_trap();
    want <= '0;
    want.halt_strap <= 1'b1;
    want.b <= 18'h0_0005;
    wr(`REG_B_CARE, 32'h0003_ffff, rsp);
    wr(`REG_B_VALUE, 32'h0000_0005, rsp);
    wr(`REG_CTRL, 32'h0000_0051, rsp);
    manual_clear();
    want.c[0] <= 1'b1;
    settle(60);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("differ no trap", 32'h0000_0002, rd & 32'h0000_0003);
    want.c[0] <= 1'b0;
    wr(`REG_CTRL, 32'h0000_0011, rsp);
    manual_clear();
    settle(8);
    want.c[0] <= 1'b1;
    check_pulse(`PULSE_CYC);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("hold trap", 32'h0000_0003, rd & 32'h0000_0003);
    cmp_bit("halt request", 1'b1, processor_halt_request);
    rdr(`REG_BANK_B, rd, rsp);
    cmp_word("sampled bank b", 32'h0000_0005, rd);
    wr(`REG_CTRL, 32'h0000_0111, rsp);
    want.end_of_operation_one <= 1'b1;
    settle(10);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("auto keeps trap", 32'h0000_0001, rd & 32'h0000_0001);
    rdr(`REG_BANK_B, rd, rsp);
    cmp_word("auto keeps banks", 32'h0000_0005, rd);
    manual_clear();
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("manual clears trap", 32'h0000_0000, rd & 32'h0000_0003);
    cmp_bit("halt drop", 1'b0, processor_halt_request);
  endtask : t_sampled_trap

  // Trigger mode waits for a bank B match, then an error trap blocks a later sample
  task automatic t_trigger_error();
    want.c[0] <= 1'b0;
    want.b <= 18'h0_0000;
    wr(`REG_CTRL, 32'h0000_0025, rsp);
    manual_clear();
    want.c[0] <= 1'b1;
    want.probe <= 1'b1;
    settle(12);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("trigger waits for match", 32'h0000_0000, rd & 32'h0000_0003);
    want.a <= 18'h0_0021;
    want.b <= 18'h0_0005;
    check_pulse(`PULSE_CYC);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("trigger trap", 32'h0000_0003, rd & 32'h0000_0003);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("trigger bank a", 32'h0000_0021, rd);
    want.probe <= 1'b0;
    wr(`REG_CTRL, 32'h0000_0085, rsp);
    manual_clear();
    settle(8);
    want.device_error <= 1'b1;
    settle(10);
    want.probe <= 1'b1;
    settle(10);
    rdr(`REG_STATUS, rd, rsp);
    cmp_word("error hold trap", 32'h0000_0001, rd & 32'h0000_0003);
    rdr(`REG_BANK_A, rd, rsp);
    cmp_word("error before sample", 32'h0000_0000, rd);
    cmp_bit("halt on error trap", 1'b1, processor_halt_request);
  endtask : t_trigger_error

  initial begin
    error_cnt = 0;
    checks_done = 0;
    reset = 1'b1;
    want = '0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    settle(6);
    t_reset_values();
    t_follow();
    t_gated();
    t_sampled_trap();
    t_trigger_error();
    end_of_test();
  end
endmodule : tb_signal_capture_trap_monitor
